// ===== dv/ldc_monitor.sv
// Port checker for the ladder converter control block
`timescale 1ns/1ps
`default_nettype none

module ldc_monitor
  import ldc_pkg::*;
#(
  parameter int unsigned ADDR_W   = LDC_ADDR_W,
  parameter int unsigned DATA_W   = LDC_DATA_W,
  parameter int unsigned CODE_W   = LDC_CODE_W,
  parameter int unsigned NUM_PINS = LDC_NUM_PINS
) (
  input wire logic                mclk,
  input wire logic                resetn,
  input wire logic [ADDR_W-1:0]   reg_addr,
  input wire logic [DATA_W-1:0]   reg_wdata,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [DATA_W-1:0]   reg_rdata,
  input wire logic                converter_enable,
  input wire logic [CODE_W-1:0]   level_code,
  input wire logic [2:0]          positive_source_select,
  input wire logic [NUM_PINS-1:0] pad_read_raw,
  input wire logic [NUM_PINS-1:0] pad_read,
  input wire logic [NUM_PINS-1:0] reference_out_connect,
  input wire logic [NUM_PINS-1:0] pad_dig_out_off,
  input wire logic [NUM_PINS-1:0] pad_in_detect_off,
  input wire logic [NUM_PINS-1:0] pad_pullup_off,
  input wire logic [NUM_PINS-1:0] pad_cc_drive_off
);
  // Strobe decode per register
  wire wr_main = reg_wr && (reg_addr == LDC_OFF_MAIN);
  wire wr_lvl  = reg_wr && (reg_addr == LDC_OFF_LEVEL);
  wire rd_main = reg_rd && (reg_addr == LDC_OFF_MAIN);
  wire rd_lvl  = reg_rd && (reg_addr == LDC_OFF_LEVEL);

  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  //////////////////////////////////////////////////////////////////////////////
  en_write_a:
    assert property (wr_main |=> converter_enable == $past(reg_wdata[7]))
      else $error("enable does not follow the main write");
  pin_write_a:
    assert property (wr_main |=> reference_out_connect == {$past(reg_wdata[4]), $past(reg_wdata[5])})
      else $error("pin routing does not follow the main write");
  src_decode_a:
    assert property (wr_main |=> positive_source_select == (($past(reg_wdata[3:2]) == 2'h3) ?
                     3'h0 : (3'h1 << $past(reg_wdata[3:2]))))
      else $error("source select decode wrong");
  code_write_a:
    assert property (wr_lvl |=> level_code == $past(reg_wdata[4:0]))
      else $error("level code does not follow the write");
  idle_hold_a:
    assert property (!reg_wr |=> $stable(converter_enable) && $stable(level_code)
                     && $stable(reference_out_connect))
      else $error("control output changed without a write");
  pin_takeover_a:
    assert property (pad_dig_out_off == reference_out_connect && pad_in_detect_off ==
                     reference_out_connect && pad_pullup_off == reference_out_connect
                     && pad_cc_drive_off == reference_out_connect)
      else $error("pin takeover does not match routing");
  read_mask_a:
    assert property (pad_read == (pad_read_raw & ~reference_out_connect))
      else $error("routed pin does not read zero");
  main_unimpl_a:
    assert property (rd_main |=> reg_rdata[6] == 1'b0 && reg_rdata[1:0] == 2'h0)
      else $error("main register unused bits not zero");
  level_read_a:
    assert property (rd_lvl |=> reg_rdata == {3'h0, level_code})
      else $error("level register read image wrong");
  reset_clear_a:
    assert property ($rose(resetn) |-> !converter_enable && level_code == 5'h00
                     && reference_out_connect == 2'h0)
      else $error("outputs not cleared by reset");
endmodule : ldc_monitor

`default_nettype wire

// ===== dv/tb.sv
// Self-checking bench for the ladder converter control block
`timescale 1ns/1ps
`default_nettype none

module tb;
  import ldc_pkg::*;
  logic       mclk         = 1'b0;
  logic       resetn       = 1'b0;
  logic [7:0] reg_addr     = 8'h00;
  logic [7:0] reg_wdata    = 8'h00;
  logic       reg_wr       = 1'b0;
  logic       reg_rd       = 1'b0;
  logic [1:0] pad_read_raw = 2'h3;
  logic [7:0] reg_rdata;
  logic       converter_enable;
  logic [4:0] level_code;
  logic [2:0] positive_source_select;
  logic [1:0] pad_read, reference_out_connect, pad_dig_out_off;
  logic [1:0] pad_in_detect_off, pad_pullup_off, pad_cc_drive_off;
  logic [7:0] pin_v [3] = '{8'h20, 8'h10, 8'h00};
  logic [1:0] con_v [3] = '{2'h1, 2'h2, 2'h0};
  logic [7:0] code_v [4] = '{8'h00, 8'h01, 8'h10, 8'h1F};
  int         failures = 0;
  int         comparisons = 0;

  always #20 mclk = ~mclk;

  ldc_top dut (.mclk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .converter_enable, .level_code, .positive_source_select, .pad_read_raw, .pad_read,
    .reference_out_connect, .pad_dig_out_off, .pad_in_detect_off, .pad_pullup_off,
    .pad_cc_drive_off);

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One-cycle write strobe; outputs settle before the negedge return
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(negedge mclk);
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk(what, reg_rdata, exp);
  endtask : rd

  task automatic results;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results

  // Hang guard
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    results();
  end

  initial begin
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    rd(LDC_OFF_MAIN, 8'h00, "main");
    rd(LDC_OFF_LEVEL, 8'h00, "level");
    $display("test reset done");
    // Every writable bit set, but the source field avoids the reserved code
    wr(LDC_OFF_MAIN, 8'hF7);
    chk("enable", {7'h0, converter_enable}, 8'h01);
    chk("connect", {6'h0, reference_out_connect}, 8'h03);
    chk("takeover", {pad_dig_out_off, pad_in_detect_off, pad_pullup_off, pad_cc_drive_off},
        8'hFF);
    chk("pad read", {6'h0, pad_read}, 8'h00);
    chk("source", {5'h0, positive_source_select}, 8'h02);
    rd(LDC_OFF_MAIN, 8'hB4, "main");
    rd(LDC_OFF_STATUS, 8'hB2, "status");
    $display("test main fields done");
    // Each non-reserved source code, with pin 1, then pin 2, then no pin
    for (int i = 0; i < 3; i++) begin
      wr(LDC_OFF_MAIN, pin_v[i] | 8'(i << 2));
      chk("source", {5'h0, positive_source_select}, 8'(3'h1 << i));
      chk("enable", {7'h0, converter_enable}, 8'h00);
      chk("connect", {6'h0, reference_out_connect}, {6'h0, con_v[i]});
      chk("pullup off", {6'h0, pad_pullup_off}, {6'h0, con_v[i]});
      chk("pad read", {6'h0, pad_read}, {6'h0, ~con_v[i]});
    end
    $display("test sources done");
    // Code boundaries with the unused upper bits set
    foreach (code_v[i]) begin
      wr(LDC_OFF_LEVEL, 8'hE0 | code_v[i]);
      chk("code", {3'h0, level_code}, code_v[i]);
    end
    $display("test codes done");
    wr(LDC_OFF_MAIN, 8'h80);
    wr(LDC_OFF_STATUS, 8'h00);
    rd(LDC_OFF_STATUS, 8'h81, "status kept");
    wr(8'h07, 8'h00);
    rd(8'h07, 8'h00, "unmapped");
    repeat (10) @(posedge mclk);
    @(negedge mclk);
    chk("code kept", {3'h0, level_code}, 8'h1F);
    chk("enable kept", {7'h0, converter_enable}, 8'h01);
    $display("test refused and hold done");
    // Reset edges move on the rising clock edge like every other input
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk("enable", {7'h0, converter_enable}, 8'h00);
    chk("code", {3'h0, level_code}, 8'h00);
    @(posedge mclk);
    resetn <= 1'b1;
    rd(LDC_OFF_MAIN, 8'h00, "main");
    $display("test mid reset done");
    results();
  end
endmodule : tb

bind ldc_top ldc_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .CODE_W(CODE_W),
  .NUM_PINS(NUM_PINS)) u_mon (.mclk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .converter_enable, .level_code, .positive_source_select, .pad_read_raw,
  .pad_read, .reference_out_connect, .pad_dig_out_off, .pad_in_detect_off,
  .pad_pullup_off, .pad_cc_drive_off);

`default_nettype wire

// ===== rtl/ldc_pin_ctrl.sv
// Pin takeover for one converter reference output pin
`timescale 1ns/1ps
`default_nettype none

module ldc_pin_ctrl
  import ldc_pkg::*;
(
  input  wire logic route_en,
  input  wire logic pad_read_raw,
  output logic      analog_connect,
  output logic      dig_out_off,
  output logic      in_detect_off,
  output logic      pullup_off,
  output logic      cc_drive_off,
  output logic      pad_read
);

  // Every digital function yields while the pin carries the reference
  assign analog_connect = route_en;
  assign dig_out_off    = route_en;
  assign in_detect_off  = route_en;
  assign pullup_off     = route_en;
  assign cc_drive_off   = route_en;

  // Detector is off, so a read must not see a floating level
  assign pad_read = pad_read_raw & ~route_en;

endmodule : ldc_pin_ctrl

`default_nettype wire

// ===== rtl/ldc_pkg.sv
// Constants, field layout and source decode for the ladder converter control block
//////////////////////////////////////////////////////////////////////////////////////////////////
`default_nettype none

package ldc_pkg;

  // Register bus shape
  localparam int unsigned LDC_ADDR_W = 8;
  localparam int unsigned LDC_DATA_W = 8;

  // Register offsets
  localparam logic [LDC_ADDR_W-1:0] LDC_OFF_MAIN   = 8'h00;
  localparam logic [LDC_ADDR_W-1:0] LDC_OFF_LEVEL  = 8'h01;
  localparam logic [LDC_ADDR_W-1:0] LDC_OFF_STATUS = 8'h02;

  // Main control register fields
  localparam int unsigned LDC_BIT_ENABLE  = 7;
  localparam int unsigned LDC_BIT_PIN1    = 5;
  localparam int unsigned LDC_BIT_PIN2    = 4;
  localparam int unsigned LDC_PSS_HI      = 3;
  localparam int unsigned LDC_PSS_LO      = 2;
  localparam int unsigned LDC_BIT_NSS     = 0;

  // Level register field
  localparam int unsigned LDC_CODE_W      = 5;
  localparam int unsigned LDC_CODE_HI     = 4;
  localparam int unsigned LDC_CODE_LO     = 0;

  // Status register fields
  localparam int unsigned LDC_ST_ENABLE   = 7;
  localparam int unsigned LDC_ST_PIN1     = 5;
  localparam int unsigned LDC_ST_PIN2     = 4;
  localparam int unsigned LDC_ST_RSVD     = 3;
  localparam int unsigned LDC_ST_SRC_HI   = 2;
  localparam int unsigned LDC_ST_SRC_LO   = 0;

  // Number of output pins and reset values
  localparam int unsigned      LDC_NUM_PINS   = 2;
  localparam logic [7:0]       LDC_RST_BYTE   = 8'h00;
  localparam logic [1:0]       LDC_RST_PSS    = 2'h0;
  localparam logic [4:0]       LDC_RST_CODE   = 5'h00;

  // Positive source field encodings
  localparam logic [1:0] LDC_PSS_SUPPLY = 2'h0;
  localparam logic [1:0] LDC_PSS_EXTREF = 2'h1;
  localparam logic [1:0] LDC_PSS_FIXED  = 2'h2;

  // One-hot positive source selection seen by the ladder switches
  typedef enum logic [2:0] {
    LDC_SRC_NONE   = 3'b000,
    LDC_SRC_SUPPLY = 3'b001,
    LDC_SRC_EXTREF = 3'b010,
    LDC_SRC_FIXED  = 3'b100
  } ldc_src_t;

  // Reserved code opens every switch so no two sources short
  function automatic ldc_src_t ldc_decode_src(input logic [1:0] pss);
    ldc_src_t src;
    src = LDC_SRC_NONE;
    unique case (pss)
      LDC_PSS_SUPPLY: src = LDC_SRC_SUPPLY;
      LDC_PSS_EXTREF: src = LDC_SRC_EXTREF;
      LDC_PSS_FIXED:  src = LDC_SRC_FIXED;
      default:        src = LDC_SRC_NONE;
    endcase
    return src;
  endfunction : ldc_decode_src

endpackage : ldc_pkg

`default_nettype wire

// ===== rtl/ldc_top.sv
// Register file and ladder control outputs of the 5-bit reference converter
`timescale 1ns/1ps
`default_nettype none

module ldc_top
  import ldc_pkg::*;
#(
  parameter int unsigned ADDR_W   = LDC_ADDR_W,
  parameter int unsigned DATA_W   = LDC_DATA_W,
  parameter int unsigned CODE_W   = LDC_CODE_W,
  parameter int unsigned NUM_PINS = LDC_NUM_PINS
) (
  input  wire logic                mclk,
  input  wire logic                resetn,
  // Register port
  input  wire logic [ADDR_W-1:0]   reg_addr,
  input  wire logic [DATA_W-1:0]   reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [DATA_W-1:0]   reg_rdata,
  // Ladder control
  output logic                     converter_enable,
  output logic      [CODE_W-1:0]   level_code,
  output logic      [2:0]          positive_source_select,
  // Reference output pins
  input  wire logic [NUM_PINS-1:0] pad_read_raw,
  output logic      [NUM_PINS-1:0] pad_read,
  output logic      [NUM_PINS-1:0] reference_out_connect,
  output logic      [NUM_PINS-1:0] pad_dig_out_off,
  output logic      [NUM_PINS-1:0] pad_in_detect_off,
  output logic      [NUM_PINS-1:0] pad_pullup_off,
  output logic      [NUM_PINS-1:0] pad_cc_drive_off
);

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Address decode
  //////////////////////////////////////////////////////////////////////////////////////////////

  logic                  hit_main;
  logic                  hit_level;
  logic                  hit_status;
  logic                  wr_main;
  logic                  wr_level;

  // Full address compare, so aliases of the registers do not exist
  assign hit_main   = (reg_addr == ADDR_W'(LDC_OFF_MAIN));
  assign hit_level  = (reg_addr == ADDR_W'(LDC_OFF_LEVEL));
  assign hit_status = (reg_addr == ADDR_W'(LDC_OFF_STATUS));

  // Status is read-only; writes there are dropped
  assign wr_main    = reg_wr & hit_main;
  assign wr_level   = reg_wr & hit_level;

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Main control register
  //////////////////////////////////////////////////////////////////////////////////////////////

  logic                  enable_q;
  logic                  enable_d;
  logic                  pin1_q;
  logic                  pin1_d;
  logic                  pin2_q;
  logic                  pin2_d;
  logic [1:0]            pss_q;
  logic [1:0]            pss_d;

  // Only implemented bits are stored; the negative select has no storage
  assign enable_d = wr_main ? reg_wdata[LDC_BIT_ENABLE] : enable_q;
  assign pin1_d   = wr_main ? reg_wdata[LDC_BIT_PIN1]   : pin1_q;
  assign pin2_d   = wr_main ? reg_wdata[LDC_BIT_PIN2]   : pin2_q;
  assign pss_d    = wr_main ? reg_wdata[LDC_PSS_HI:LDC_PSS_LO] : pss_q;

  // Reset is the only clearing path; Sleep and wake leave the bits alone
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      enable_q <= LDC_RST_BYTE[LDC_BIT_ENABLE];
      pin1_q   <= LDC_RST_BYTE[LDC_BIT_PIN1];
      pin2_q   <= LDC_RST_BYTE[LDC_BIT_PIN2];
      pss_q    <= LDC_RST_PSS;
    end else begin
      enable_q <= enable_d;
      pin1_q   <= pin1_d;
      pin2_q   <= pin2_d;
      pss_q    <= pss_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Level register
  //////////////////////////////////////////////////////////////////////////////////////////////

  logic [CODE_W-1:0]     code_q;
  logic [CODE_W-1:0]     code_d;

  // Upper bits of the write data are unimplemented and ignored
  assign code_d = wr_level ? reg_wdata[CODE_W-1:0] : code_q;

  // Cleared by reset only, as the other control bits
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      code_q <= CODE_W'(LDC_RST_CODE);
    end else begin
      code_q <= code_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Ladder control outputs
  //////////////////////////////////////////////////////////////////////////////////////////////

  ldc_src_t              src_sel;
  logic                  src_reserved;

  // Decode of the stored field; the reserved code opens every source switch
  assign src_sel      = ldc_decode_src(pss_q);
  assign src_reserved = (src_sel == LDC_SRC_NONE);

  // Straight from the flops: a write shows on the edge that takes it, no staging
  assign converter_enable       = enable_q;
  assign level_code             = code_q;
  assign positive_source_select = src_sel;

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Pin takeover
  //////////////////////////////////////////////////////////////////////////////////////////////

  logic [NUM_PINS-1:0]   route_en;

  // Routing does not depend on the enable bit; a disabled ladder still owns the pin
  assign route_en = {pin2_q, pin1_q};

  // One takeover block per reference output pin
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      ldc_pin_ctrl u_pin (
        .route_en       (route_en[gi]),
        .pad_read_raw   (pad_read_raw[gi]),
        .analog_connect (reference_out_connect[gi]),
        .dig_out_off    (pad_dig_out_off[gi]),
        .in_detect_off  (pad_in_detect_off[gi]),
        .pullup_off     (pad_pullup_off[gi]),
        .cc_drive_off   (pad_cc_drive_off[gi]),
        .pad_read       (pad_read[gi])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Read-back images
  //////////////////////////////////////////////////////////////////////////////////////////////

  logic [DATA_W-1:0]     main_image;
  logic [DATA_W-1:0]     level_image;
  logic [DATA_W-1:0]     status_image;

  // Main register image; gaps and the negative select stay zero
  always_comb begin
    main_image                        = '0;
    main_image[LDC_BIT_ENABLE]        = enable_q;
    main_image[LDC_BIT_PIN1]          = pin1_q;
    main_image[LDC_BIT_PIN2]          = pin2_q;
    main_image[LDC_PSS_HI:LDC_PSS_LO] = pss_q;
    main_image[LDC_BIT_NSS]           = 1'b0;
  end

  // Level image; bits above the code read zero
  always_comb begin
    level_image                           = '0;
    level_image[LDC_CODE_HI:LDC_CODE_LO]  = code_q;
  end

  // Live state of the ladder switches and pins
  always_comb begin
    status_image                              = '0;
    status_image[LDC_ST_ENABLE]               = converter_enable;
    status_image[LDC_ST_PIN1]                 = reference_out_connect[0];
    status_image[LDC_ST_PIN2]                 = reference_out_connect[1];
    status_image[LDC_ST_RSVD]                 = src_reserved;
    status_image[LDC_ST_SRC_HI:LDC_ST_SRC_LO] = src_sel;
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Read data
  //////////////////////////////////////////////////////////////////////////////////////////////

  logic [DATA_W-1:0]     rd_mux;
  logic [DATA_W-1:0]     rdata_q;
  logic [DATA_W-1:0]     rdata_d;

  // Unmapped offsets answer zero
  assign rd_mux = hit_main   ? main_image   :
                  hit_level  ? level_image  :
                  hit_status ? status_image : '0;

  // Data stand only in the cycle after the strobe, zero otherwise
  assign rdata_d = reg_rd ? rd_mux : '0;

  // Read flop
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= DATA_W'(LDC_RST_BYTE);
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

endmodule : ldc_top

`default_nettype wire
